// ### src/qsf_controller.sv
// Quad serial flash controller: frame sequencer, shifters and mapped reads
`timescale 1ns/10ps
module qsf_controller import qsf_pkg::*; (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Configuration
  input wire logic [DIV_W-1:0] serial_clock_divide_factor_in,
  input wire logic [1:0] select_to_data_delay_field_in,
  input wire logic [1:0] read_lanes_in,
  input wire logic word_irq_en_in,
  input wire logic frame_irq_en_in,
  input wire logic [7:0] mm_read_cmd_in,
  // Command port
  input wire logic cmd_start_in,
  input wire logic cmd_write_in,
  input wire logic [LEN_W-1:0] cmd_word_len_in,
  input wire logic [CNT_W-1:0] cmd_word_count_in,
  input wire logic [WORD_MAX-1:0] cmd_tx_data_in,
  output logic cmd_ready_out,
  output logic [WORD_MAX-1:0] rx_data_out,
  output logic rx_valid_out,
  output logic word_done_out,
  // Memory-mapped read port
  input wire logic mm_req_in,
  input wire logic [MM_ADDR_W-1:0] mm_addr_in,
  output logic mm_ready_out,
  output logic mm_ack_out,
  output logic [MM_DATA_W-1:0] mm_rdata_out,
  // Status and interrupts
  output logic busy_out,
  output logic word_irq_out,
  output logic frame_irq_out,
  // Serial pins
  output logic sclk_out,
  output logic cs_n_out,
  output logic [3:0] data_out,
  output logic [3:0] data_oe_out,
  input wire logic [3:0] data_in
);

  // ****************************************************************
  // State and datapath registers
  // ****************************************************************
  qsf_state_e state_q; // Frame sequencer state
  logic is_mm_q; // Frame serves a mapped read
  logic write_q; // Current word is shifted out
  logic [LEN_W-1:0] len_q; // Current word length minus one
  logic [CNT_W-1:0] words_left_q; // Words still to go, minus one
  logic [BITS_W-1:0] bits_q; // Bits already moved in this word
  logic [1:0] lanes_q; // Read lane mode for the frame
  logic [1:0] dd_q; // Select-to-data delay for the frame
  logic [DIV_W-1:0] fac_q; // Divide factor for the frame
  logic [1:0] gap_q; // Lead or trail period counter
  logic [WORD_MAX-1:0] tx_q; // Left-aligned output shifter
  logic [WORD_MAX-1:0] rx_q; // Input shifter
  logic sclk_q; // Serial clock level
  logic cs_q; // Select active
  logic out_q; // Output bit on line 0
  logic [WORD_MAX-1:0] rx_data_q; // Last read word
  logic rx_valid_q; // Read word pulse
  logic word_done_q; // Word pulse
  logic [MM_DATA_W-1:0] mm_rdata_q; // Mapped read data
  logic mm_ack_q; // Mapped read answer pulse
  logic word_irq_q; // Gated word interrupt pulse
  logic frame_irq_q; // Gated frame interrupt pulse

  // ****************************************************************
  // Divider
  // ****************************************************************
  logic rise_tick; // Clock rises at the coming edge
  logic fall_tick; // Clock falls at the coming edge

  qsf_clk_div u_div (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .run_in(state_q != ST_IDLE),
    .factor_in(fac_q),
    .rise_tick_out(rise_tick),
    .fall_tick_out(fall_tick)
  );

  // ****************************************************************
  // Per-edge arithmetic
  // ****************************************************************
  logic [BITS_W-1:0] step; // Bits moved per falling edge
  logic [BITS_W-1:0] bits_next; // Bits done after this edge
  logic word_end; // This fall finishes the word
  logic frame_end; // This fall finishes the frame
  logic [3:0] sample; // Bits taken from the lines
  logic [WORD_MAX-1:0] rx_shift; // Input shifter after this edge
  logic [WORD_MAX-1:0] next_tx; // Data of the next command word
  logic shift_fall; // Falling edge while shifting

  // In read words the lane count selects how many lines are sampled at each fall; write words sample line 1 only
  always_comb begin
    step = 8'h01;
    sample = {3'h0, data_in[1]};
    if (!write_q) begin
      case (lanes_q)
        LANES_DUAL: begin
          step = 8'h02;
          sample = {2'h0, data_in[1:0]};
        end
        LANES_QUAD: begin
          step = 8'h04;
          sample = data_in;
        end
        default: begin // Single line
          step = 8'h01;
          sample = {3'h0, data_in[1]};
        end
      endcase
    end
    shift_fall = (state_q == ST_SHIFT) && fall_tick;
    bits_next = bits_q + step;
    // A length not a multiple of the lanes rounds up to whole edges
    word_end = (bits_next > {1'b0, len_q});
    frame_end = word_end && (words_left_q == '0);
    rx_shift = (rx_q << step) | {124'h0, sample};
    next_tx = cmd_tx_data_in << (7'h7f - len_q);
  end

  // ****************************************************************
  // Frame sequencer
  // ****************************************************************
  // Requests are taken only when idle; the command port wins a tie
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state_q <= ST_IDLE;
      is_mm_q <= 1'b0;
      write_q <= 1'b0;
      len_q <= '0;
      words_left_q <= '0;
      lanes_q <= LANES_SINGLE;
      dd_q <= '0;
      fac_q <= '0;
      gap_q <= '0;
      cs_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          gap_q <= '0;
          if (cmd_start_in) begin
            state_q <= ST_ARM;
            is_mm_q <= 1'b0;
            write_q <= cmd_write_in;
            len_q <= cmd_word_len_in;
            words_left_q <= cmd_word_count_in;
            lanes_q <= read_lanes_in;
            dd_q <= select_to_data_delay_field_in;
            fac_q <= serial_clock_divide_factor_in;
          end else if (mm_req_in) begin
            state_q <= ST_ARM;
            is_mm_q <= 1'b1;
            write_q <= 1'b1;
            len_q <= MM_HDR_LEN;
            words_left_q <= MM_WORDS;
            lanes_q <= read_lanes_in;
            dd_q <= select_to_data_delay_field_in;
            fac_q <= serial_clock_divide_factor_in;
          end
        end
        ST_ARM: begin
          // Select goes active on a fall tick, with the clock held low
          if (fall_tick) begin
            cs_q <= 1'b1;
            gap_q <= 2'h1;
            state_q <= (dd_q == 2'h0) ? ST_SHIFT : ST_LEAD;
          end
        end
        ST_LEAD: begin
          // Each tick is one idle period; the last one leads the first fall
          if (fall_tick) begin
            if (gap_q == dd_q) begin
              state_q <= ST_SHIFT;
            end else begin
              gap_q <= gap_q + 2'h1;
            end
          end
        end
        ST_SHIFT: begin
          if (shift_fall && word_end) begin
            if (frame_end) begin
              state_q <= ST_TRAIL;
              gap_q <= '0;
            end else begin
              // Select stays active between words
              words_left_q <= words_left_q - 12'h001;
              if (is_mm_q) begin
                write_q <= 1'b0;
                len_q <= MM_DATA_LEN;
              end
            end
          end
        end
        ST_TRAIL: begin
          if (fall_tick) begin
            if (gap_q == TRAIL_PERIODS - 2'h1) begin
              cs_q <= 1'b0;
              state_q <= ST_IDLE;
            end else begin
              gap_q <= gap_q + 2'h1;
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
          cs_q <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************************************
  // Serial clock
  // ****************************************************************
  // Toggles only inside the shift phase, so it rests low outside frames
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      sclk_q <= SCLK_IDLE;
    end else if ((state_q == ST_SHIFT) && rise_tick) begin
      sclk_q <= 1'b1;
    end else if (shift_fall || (state_q != ST_SHIFT)) begin
      sclk_q <= SCLK_IDLE;
    end
  end

  // ****************************************************************
  // Bit counter and output shifter
  // ****************************************************************
  // The first bit goes out on entry to the shift phase, one period
  // ahead of the first fall; later bits change on each fall
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      bits_q <= '0;
      tx_q <= WORD_RST;
      out_q <= 1'b0;
    end else if (state_q == ST_IDLE) begin
      bits_q <= '0;
      out_q <= 1'b0;
      if (cmd_start_in) begin
        tx_q <= cmd_tx_data_in << (7'h7f - cmd_word_len_in);
      end else if (mm_req_in) begin
        tx_q <= {mm_read_cmd_in, mm_addr_in, 96'h0};
      end
    end else if (fall_tick && ((state_q == ST_ARM && dd_q == 2'h0) ||
                 (state_q == ST_LEAD && gap_q == dd_q))) begin
      out_q <= tx_q[WORD_MAX-1];
    end else if (shift_fall) begin
      if (word_end) begin
        bits_q <= '0;
        tx_q <= next_tx;
        out_q <= next_tx[WORD_MAX-1] & ~is_mm_q;
      end else begin
        bits_q <= bits_next;
        tx_q <= tx_q << 1;
        out_q <= tx_q[WORD_MAX-2];
      end
    end
  end

  // ****************************************************************
  // Input shifter and read results
  // ****************************************************************
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || state_q == ST_IDLE) begin
      rx_q <= WORD_RST;
    end else if (shift_fall) begin
      rx_q <= word_end ? WORD_RST : rx_shift;
    end
  end

  // Completed read words; mapped reads answer on their own port
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rx_data_q <= WORD_RST;
      rx_valid_q <= 1'b0;
      mm_rdata_q <= '0;
      mm_ack_q <= 1'b0;
    end else begin
      rx_valid_q <= shift_fall && word_end && !write_q && !is_mm_q;
      mm_ack_q <= shift_fall && word_end && !write_q && is_mm_q;
      if (shift_fall && word_end && !write_q) begin
        if (is_mm_q) begin
          mm_rdata_q <= rx_shift[MM_DATA_W-1:0];
        end else begin
          rx_data_q <= rx_shift;
        end
      end
    end
  end

  // ****************************************************************
  // Completion pulses
  // ****************************************************************
  // Frame completion is reported when select is released
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      word_done_q <= 1'b0;
      word_irq_q <= 1'b0;
      frame_irq_q <= 1'b0;
    end else begin
      word_done_q <= shift_fall && word_end;
      word_irq_q <= shift_fall && word_end && word_irq_en_in;
      frame_irq_q <= (state_q == ST_TRAIL) && fall_tick &&
                     (gap_q == TRAIL_PERIODS - 2'h1) && frame_irq_en_in;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign cmd_ready_out = (state_q == ST_IDLE);
  assign mm_ready_out = (state_q == ST_IDLE) && !cmd_start_in;
  assign busy_out = (state_q != ST_IDLE);
  assign rx_data_out = rx_data_q;
  assign rx_valid_out = rx_valid_q;
  assign word_done_out = word_done_q;
  assign mm_rdata_out = mm_rdata_q;
  assign mm_ack_out = mm_ack_q;
  assign word_irq_out = word_irq_q;
  assign frame_irq_out = frame_irq_q;
  assign sclk_out = sclk_q;
  assign cs_n_out = ~cs_q;
  // Only line 0 is ever driven, and only while select is active and write_q is set, lead and trail included
  assign data_out = {3'h0, out_q};
  assign data_oe_out = {3'h0, cs_q & write_q};

endmodule // qsf_controller

// ### src/qsf_pkg.sv
// Shared constants, encodings and states of the quad serial flash controller
package qsf_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int DIV_W = 8; // Width of the clock divide factor
  localparam int WORD_MAX = 128; // Longest word in bits
  localparam int LEN_W = 7; // Word length field, value is length minus one
  localparam int CNT_W = 12; // Word count field, value is count minus one
  localparam int BITS_W = 8; // Bits-done counter, reaches WORD_MAX
  localparam int MM_ADDR_W = 24; // Byte address of a mapped read
  localparam int MM_DATA_W = 32; // Data returned by one mapped read

  // ****************************************************************
  // Lane modes and fixed clock mode
  // ****************************************************************
  localparam logic [1:0] LANES_SINGLE = 2'h0; // One line, input on line 1
  localparam logic [1:0] LANES_DUAL = 2'h1; // Lines 1..0
  localparam logic [1:0] LANES_QUAD = 2'h2; // Lines 3..0
  localparam logic CLOCK_PHASE_SETTING = 1'b0; // Clock mode 0 only, idle low
  localparam logic SCLK_IDLE = 1'b0; // Serial clock rest level

  // ****************************************************************
  // Timing counts, in serial clock periods or functional clock cycles
  // ****************************************************************
  localparam logic [DIV_W:0] CLK_MIN_PERIOD = 9'h002; // Factor zero still needs two cycles
  localparam logic [1:0] TRAIL_PERIODS = 2'h2; // Select held after the last fall

  // ****************************************************************
  // Mapped read frame layout
  // ****************************************************************
  localparam logic [LEN_W-1:0] MM_HDR_LEN = 7'h1f; // Command plus address, 32 bits
  localparam logic [LEN_W-1:0] MM_DATA_LEN = 7'h1f; // Read data word, 32 bits
  localparam logic [CNT_W-1:0] MM_WORDS = 12'h001; // Two words, minus one

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [WORD_MAX-1:0] WORD_RST = '0; // Shift and data registers

  // Frame sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ARM,
    ST_LEAD,
    ST_SHIFT,
    ST_TRAIL
  } qsf_state_e;

endpackage

// ### src/qsf_clk_div.sv
// Serial clock divider producing rise and fall enable pulses
`timescale 1ns/10ps
module qsf_clk_div import qsf_pkg::*; (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic run_in, // Divider counts only while a frame is open
  input wire logic [DIV_W-1:0] factor_in, // Latched divide factor
  output logic rise_tick_out, // Serial clock goes high at the next edge
  output logic fall_tick_out // Serial clock goes low at the next edge
);

  // ****************************************************************
  // Period and high phase
  // ****************************************************************
  logic [DIV_W:0] period; // Serial period in functional clocks
  logic [DIV_W:0] high_len; // Cycles spent high in each period
  logic [DIV_W:0] cnt_q; // Position inside the period

  // Odd factors give an even period and an exact half duty; even nonzero ones
  // give factor/2 high out of factor+1, so duty is slightly distorted
  always_comb begin
    period = (factor_in == '0) ? CLK_MIN_PERIOD : ({1'b0, factor_in} + 9'h001);
    high_len = period >> 1;
  end

  // Period counter, parked at zero between frames so phase is defined
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || !run_in) begin
      cnt_q <= '0;
    end else if (cnt_q == period - 9'h001) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 9'h001;
    end
  end

  // Ticks are combinational; the sequencer registers the clock level
  assign rise_tick_out = run_in && (cnt_q == period - 9'h001);
  assign fall_tick_out = run_in && (cnt_q == high_len - 9'h001);

endmodule // qsf_clk_div

// ### tb/qsf_flash_model.sv
// Behavioural serial flash model driving the controller's input lines
`timescale 1ns/10ps
module qsf_flash_model (
  input wire logic clk_in,
  input wire logic sclk_in, // Serial clock from the controller
  input wire logic cs_n_in, // Active low select from the controller
  input wire logic [3:0] line_in, // Lines driven by the controller
  input wire logic [3:0] line_oe_in, // Controller drive enables
  input wire logic [3:0] seed_in, // First nibble of every frame
  output logic [3:0] line_out, // Lines towards the controller
  output logic [127:0] wr_bits_out = '0 // Bits written to us, newest lowest
);
  logic [3:0] nib_q = 4'h0; // Nibble presented while selected
  logic [3:0] idle_q = 4'h5; // Toggling junk while not selected

  // ****************************************************************
  // Read data: restart at select, advance on every falling clock
  // ****************************************************************
  always @(negedge cs_n_in) nib_q <= seed_in;
  always @(negedge sclk_in) begin
    // Launch on the fall; the sampler sees the old nibble
    if (!cs_n_in) nib_q <= nib_q + 4'h1;
  end
  // Released lines toggle, so a late sample shows up
  always @(posedge clk_in) begin
    if (cs_n_in) idle_q <= ~idle_q;
  end
  assign #1 line_out = cs_n_in ? idle_q : nib_q;

  // ****************************************************************
  // Write capture on the rising clock, where the line is settled
  // ****************************************************************
  always @(posedge sclk_in) begin
    if (!cs_n_in && line_oe_in[0]) wr_bits_out <= {wr_bits_out[126:0], line_in[0]};
  end
endmodule // qsf_flash_model

// ### tb/qsf_controller_sva.sv
// Checker of serial pin timing and event pulses of the controller
`timescale 1ns/10ps
module qsf_controller_sva import qsf_pkg::*; (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic [DIV_W-1:0] serial_clock_divide_factor_in,
  input wire logic [1:0] select_to_data_delay_field_in,
  input wire logic word_irq_en_in,
  input wire logic frame_irq_en_in,
  input wire logic cmd_start_in,
  input wire logic mm_req_in,
  input wire logic cmd_ready_out,
  input wire logic mm_ready_out,
  input wire logic mm_ack_out,
  input wire logic rx_valid_out,
  input wire logic word_done_out,
  input wire logic busy_out,
  input wire logic word_irq_out,
  input wire logic frame_irq_out,
  input wire logic sclk_out,
  input wire logic cs_n_out,
  input wire logic [3:0] data_out,
  input wire logic [3:0] data_oe_out
);
  logic [DIV_W-1:0] fac_q; // Factor of the open frame
  logic [1:0] dly_q; // Delay field of the open frame
  logic [9:0] per_w; // Serial period in functional cycles
  logic [15:0] lead_q; // Cycles since select fell
  logic [15:0] ph_q; // Cycles spent at the present clock level
  logic seen_q; // First fall of the frame already passed
  logic sclk_q; // Clock level one cycle back
  assign per_w = (fac_q == '0) ? 10'h002 : {2'h0, fac_q} + 10'h001;

  // ****************************************************************
  // Helper logic
  // ****************************************************************
  // Settings latched where the request is taken
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      fac_q <= '0;
      dly_q <= '0;
    end else if (cmd_ready_out && (cmd_start_in || mm_req_in)) begin
      fac_q <= serial_clock_divide_factor_in;
      dly_q <= select_to_data_delay_field_in;
    end
  end
  // Cycles at the present clock level, tail included
  always_ff @(posedge clk_in) begin
    sclk_q <= sys_rst_in ? 1'b0 : sclk_out;
    ph_q <= (sys_rst_in || sclk_out != sclk_q) ? 16'h0001 : ph_q + 16'h0001;
  end
  // Cycles since select fell
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || cs_n_out) begin
      lead_q <= '0;
      seen_q <= 1'b0;
    end else begin
      lead_q <= lead_q + 16'h0001;
      seen_q <= seen_q || (sclk_q && !sclk_out);
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  idle_low_a: assert property (cs_n_out |-> !sclk_out)
    else $error("serial clock high while deselected");
  upper_quiet_a: assert property (data_oe_out != 4'h0 |-> !cs_n_out && data_oe_out[3:1] == 3'h0)
    else $error("drive outside select or on upper lines");
  lead_time_a: assert property ($fell(sclk_out) && !seen_q |->
    int'(lead_q) == (int'(dly_q) + 1) * int'(per_w)) else $error("select lead wrong");
  high_phase_a: assert property ($fell(sclk_out) |-> int'(ph_q) == int'(per_w >> 1))
    else $error("clock high phase wrong");
  low_phase_a: assert property ($rose(sclk_out) && seen_q |->
    int'(ph_q) == int'(per_w - (per_w >> 1))) else $error("clock low phase wrong");
  tail_time_a: assert property ($rose(cs_n_out) |-> int'(ph_q) == 2 * int'(per_w))
    else $error("select release time wrong");
  rise_stable_a: assert property ($rose(sclk_out) |-> $stable(data_out))
    else $error("output moved at a rising clock");
  word_fall_a: assert property (word_done_out |-> $fell(sclk_out) && !cs_n_out)
    else $error("word end not on a falling clock");
  result_word_a: assert property (rx_valid_out || mm_ack_out |-> word_done_out)
    else $error("result without word end");
  word_irq_a: assert property (word_irq_out == (word_done_out && $past(word_irq_en_in)))
    else $error("word interrupt wrong");
  frame_irq_a: assert property (frame_irq_out == ($rose(cs_n_out) && $past(frame_irq_en_in)))
    else $error("frame interrupt wrong");
  ready_idle_a: assert property (mm_ready_out |-> cmd_ready_out && !cmd_start_in && !busy_out)
    else $error("mapped ready while busy");
  cover property ($rose(cs_n_out) && frame_irq_out);
  cover property (mm_ack_out);
  cover property ($fell(sclk_out) && !seen_q && dly_q == 2'h3);
endmodule // qsf_controller_sva

bind qsf_controller qsf_controller_sva chk_u (.*);

// ### tb/tb_top.sv
// Self-checking bench of the quad serial flash controller
`timescale 1ns/10ps
module tb_top import qsf_pkg::*; ;
  logic clk_in, sys_rst_in, cmd_start_in, cmd_write_in, mm_req_in, word_irq_en_in;
  logic frame_irq_en_in, cmd_ready_out, rx_valid_out, word_done_out, mm_ready_out;
  logic mm_ack_out, busy_out, word_irq_out, frame_irq_out, sclk_out, cs_n_out;
  logic [DIV_W-1:0] serial_clock_divide_factor_in;
  logic [1:0] select_to_data_delay_field_in, read_lanes_in;
  logic [7:0] mm_read_cmd_in;
  logic [LEN_W-1:0] cmd_word_len_in;
  logic [CNT_W-1:0] cmd_word_count_in;
  logic [WORD_MAX-1:0] cmd_tx_data_in, rx_data_out, wr_bits;
  logic [MM_ADDR_W-1:0] mm_addr_in;
  logic [MM_DATA_W-1:0] mm_rdata_out;
  logic [3:0] data_out, data_oe_out, data_in, seed;
  logic [31:0] lfsr_q; // Random source
  logic [127:0] rx_q[$]; // Expected command read words
  logic [127:0] mm_q[$]; // Expected mapped read data
  int error_cnt, compares, n;

  qsf_controller dut_u (.clk_in, .sys_rst_in, .serial_clock_divide_factor_in,
    .select_to_data_delay_field_in, .read_lanes_in, .word_irq_en_in, .frame_irq_en_in,
    .mm_read_cmd_in, .cmd_start_in, .cmd_write_in, .cmd_word_len_in, .cmd_word_count_in,
    .cmd_tx_data_in, .cmd_ready_out, .rx_data_out, .rx_valid_out, .word_done_out, .mm_req_in,
    .mm_addr_in, .mm_ready_out, .mm_ack_out, .mm_rdata_out, .busy_out, .word_irq_out,
    .frame_irq_out, .sclk_out, .cs_n_out, .data_out, .data_oe_out, .data_in);
  qsf_flash_model mdl_u (.clk_in, .sclk_in(sclk_out), .cs_n_in(cs_n_out), .line_in(data_out),
    .line_oe_in(data_oe_out), .seed_in(seed), .line_out(data_in), .wr_bits_out(wr_bits));

  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  // ****************************************************************
  // Checking and reference model
  // ****************************************************************
  task automatic check(input logic [127:0] seen, input logic [127:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s: got %h want %h", $time, what, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Word sent by the flash from fall f0, first bit highest
  function automatic logic [127:0] exp_word(input int f0, input int nl, input int len);
    logic [127:0] v;
    logic [3:0] nb;
    v = '0;
    for (int k = 0; k < len / nl; k++) begin
      nb = seed + 4'(f0 + k);
      v = (v << nl) | ((nl == 4) ? nb : (nl == 2) ? {2'h0, nb[1:0]} : {3'h0, nb[1]});
    end
    return v;
  endfunction
  // Results are read at the edge that ends their one-cycle pulse
  always @(posedge clk_in) begin
    if (rx_valid_out) check(rx_data_out, rx_q.size() ? rx_q.pop_front() : 'x, "read word");
    if (mm_ack_out) check(mm_rdata_out, mm_q.size() ? mm_q.pop_front() : 'x, "mapped data");
  end

  // ****************************************************************
  // Drivers
  // ****************************************************************
  task automatic setup(input int f, input int d, input int lc);
    repeat (32) lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
    @(posedge clk_in);
    #1;
    serial_clock_divide_factor_in = DIV_W'(f);
    select_to_data_delay_field_in = 2'(d);
    read_lanes_in = 2'(lc);
    seed = lfsr_q[3:0];
    word_irq_en_in = lfsr_q[4];
    frame_irq_en_in = lfsr_q[5];
    mm_read_cmd_in = lfsr_q[31:24];
    mm_addr_in = lfsr_q[23:0];
  endtask
  // Request held until taken at an edge with ready high
  task automatic req(input logic mapped, input logic wr, input int len, input int cnt);
    cmd_write_in = wr;
    cmd_word_len_in = LEN_W'(len - 1);
    cmd_word_count_in = CNT_W'(cnt - 1);
    if (mapped) mm_req_in = 1'b1;
    else cmd_start_in = 1'b1;
    while (!(mapped ? mm_ready_out : cmd_ready_out)) begin
      @(posedge clk_in);
      #1;
    end
    @(posedge clk_in);
    #1;
    if (mapped) mm_req_in = 1'b0;
    else cmd_start_in = 1'b0;
  endtask
  task automatic idle();
    n = 0;
    while (busy_out !== 1'b0 && n < 30000) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    check(busy_out, 1'b0, "frame end");
  endtask
  task automatic rd(input int f, input int d, input int lc, input int len, input int cnt);
    int nl;
    setup(f, d, lc);
    nl = (lc == 2) ? 4 : (lc == 1) ? 2 : 1;
    for (int w = 0; w < cnt; w++) rx_q.push_back(exp_word(w * len / nl, nl, len));
    req(1'b0, 1'b0, len, cnt);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    error_cnt = 0;
    compares = 0;
    lfsr_q = 32'h03c9eaa5;
    sys_rst_in = 1'b1;
    {cmd_start_in, cmd_write_in, mm_req_in, word_irq_en_in, frame_irq_en_in} = '0;
    {serial_clock_divide_factor_in, select_to_data_delay_field_in, read_lanes_in} = '0;
    {mm_read_cmd_in, mm_addr_in, cmd_word_len_in, cmd_word_count_in, seed} = '0;
    cmd_tx_data_in = '0;
    repeat (10) @(posedge clk_in);
    #1;
    sys_rst_in = 1'b0;
    // Every lane code and delay; factors zero, even, then odd ones
    for (int i = 0; i < 8; i++) begin
      rd((i < 2) ? 2 * i : 2 * int'(lfsr_q[2:0]) + 1, i % 4, i / 2, 4 * (i % 3 + 1), 2);
      idle();
    end
    rd(1, 0, 2, 128, 1);
    idle();
    rd(0, 3, 0, 1, 4096);
    idle();
    // Two written words; the second is picked up live at the first word end
    setup(3, 1, 0);
    cmd_tx_data_in = 128'h5a;
    req(1'b0, 1'b1, 8, 2);
    cmd_tx_data_in = 128'hc3;
    idle();
    check(wr_bits[15:0], 16'h5ac3, "written bits");
    // Command and mapped together: command first, mapped next
    setup(1, 2, 2);
    mm_req_in = 1'b1;
    rx_q.push_back(exp_word(0, 4, 16));
    mm_q.push_back(exp_word(32, 4, 32));
    req(1'b0, 1'b0, 16, 1);
    req(1'b1, 1'b0, 32, 1);
    idle();
    check(wr_bits[31:0], {mm_read_cmd_in, mm_addr_in}, "mapped header");
    // Requests while busy are dropped
    rd(1, 0, 1, 8, 1);
    @(posedge clk_in);
    #1;
    {cmd_start_in, mm_req_in} = 2'h3;
    repeat (3) @(posedge clk_in);
    #1;
    {cmd_start_in, mm_req_in} = 2'h0;
    idle();
    // Reset in mid-frame drops select at once
    rd(1, 0, 0, 32, 4);
    repeat (30) @(posedge clk_in);
    #1;
    sys_rst_in = 1'b1;
    @(posedge clk_in);
    #1;
    check(cs_n_out, 1'b1, "abort select");
    check(sclk_out, 1'b0, "abort clock");
    @(posedge clk_in);
    #1;
    sys_rst_in = 1'b0;
    rx_q.delete();
    rd(1, 1, 0, 8, 1);
    idle();
    check(rx_q.size() + mm_q.size(), 0, "results left over");
    conclude();
  end

  initial begin
    repeat (60000) @(posedge clk_in);
    error_cnt++;
    $display("[FAIL] %0t watchdog ran out", $time);
    conclude();
  end
endmodule // tb_top
